//--- isr_pkg.sv
// Package of constants and command codes for the status reporting block
package isr_pkg;
  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int unsigned ISR_SET_W = 16;
  localparam int unsigned ISR_SLOT_N = 50;
  localparam int unsigned ISR_SLOT_AW = 6;
  localparam logic [7:0] ISR_SLOT_FIRST = 8'h01;
  localparam logic [7:0] ISR_SLOT_LAST = 8'h32;
  // ****************************************
  // Standard event bits
  // ****************************************
  localparam int unsigned SE_OPC = 0;
  localparam int unsigned SE_QYE = 2;
  localparam int unsigned SE_DDE = 3;
  localparam int unsigned SE_EXE = 4;
  localparam int unsigned SE_CME = 5;
  localparam int unsigned SE_PON = 7;
  localparam logic [7:0] SE_USED = 8'hbd;
  // ****************************************
  // Status byte bits
  // ****************************************
  localparam int unsigned SB_QUES = 3;
  localparam int unsigned SB_ESB = 5;
  localparam int unsigned SB_RQS = 6;
  localparam int unsigned SB_OPER = 7;
  localparam logic [7:0] SB_NO_RQS = 8'hbf;
  // ****************************************
  // Condition widths and reset values
  // ****************************************
  localparam int unsigned QUES_W = 3;
  localparam int unsigned OPER_W = 5;
  localparam logic [7:0] ESR_RST = 8'h80;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_PARITY = 8'h6e;
  localparam logic [7:0] OPC_TRUE = 8'h01;
  // ****************************************
  // Command codes
  // ****************************************
  typedef enum logic [4:0] {
    ISR_CLS = 5'h00, ISR_ESE_W = 5'h01, ISR_ESE_Q = 5'h02, ISR_ESR_Q = 5'h03,
    ISR_OPC = 5'h04, ISR_OPC_Q = 5'h05, ISR_PSC_W = 5'h06, ISR_PSC_Q = 5'h07,
    ISR_RST = 5'h08, ISR_SRE_W = 5'h09, ISR_SRE_Q = 5'h0a, ISR_STB_Q = 5'h0b,
    ISR_TRG = 5'h0c, ISR_SAV = 5'h0d, ISR_RCL = 5'h0e, ISR_ERR_Q = 5'h0f,
    ISR_REM = 5'h10, ISR_LOC = 5'h11, ISR_RWL = 5'h12, ISR_QEV_Q = 5'h13,
    ISR_QCD_Q = 5'h14, ISR_QEN_W = 5'h15, ISR_QEN_Q = 5'h16, ISR_OEV_Q = 5'h17,
    ISR_OCD_Q = 5'h18, ISR_OEN_W = 5'h19, ISR_OEN_Q = 5'h1a, ISR_TRIG = 5'h1b,
    ISR_TSRC_W = 5'h1c
  } isr_cmd_t;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ISR_IDLE = 3'b001,
    ISR_RECALL = 3'b010,
    ISR_OPC_WAIT = 3'b100
  } isr_state_t;
endpackage

//--- isr_slot_mem.sv
// Setting slot memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module isr_slot_mem
  import isr_pkg::*;
(
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [ISR_SLOT_AW-1:0] wr_addr,
  input wire logic [4*ISR_SET_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [ISR_SLOT_AW-1:0] rd_addr,
  output logic [4*ISR_SET_W-1:0] rd_data
);
  logic [4*ISR_SET_W-1:0] mem [ISR_SLOT_N];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- isr_status_core.sv
// Status registers and common command logic of the remote interface
// Overview of operation
// [R1] Clear-status zeroes event, condition, status, error; code leaves questionable event and operation condition uncleared
// [R2] Standard event enable mask, writable and readable
// [R3] Standard event bits: 7,5,4,3,2,0 used
// [R4] Enabled standard event sets event summary
// [R5] Standard event read returns then clears
// [R6] Operation complete set after earlier commands finish
// [R7] Power-on clear one: reset clears enables, events; code keeps status enable mask and questionable, operation events
// [R8] Power-on clear zero: masks kept, restored; code ANDs status enable mask with saved status byte instead
// [R9] Status enable mask drives request service bit
// [R10] Status byte read returns then clears
// [R11] Status byte bits: 7,6,5,3 used
// [R12] Trigger only when trigger source is bus
// [R13] Save, recall slots 1 to 50
// [R14] Error query returns code; 110 is parity
// [R15] Remote, local, remote lock modes
// [R16] Questionable bits: volts, thermal, regulation
// [R17] Questionable event read returns then clears
// [R18] Questionable condition change latches event
// [R19] Enabled questionable event sets questionable summary
// [R20] Operation bits 0 to 4; read clears
// [R21] Operation condition change latches event
// [R22] Enabled operation event sets operation summary
// [R23] Summaries are OR of event AND mask
// [R24] Host reads status byte, then event register
`timescale 1ns/100ps
`default_nettype none
module isr_status_core
  import isr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire isr_cmd_t cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic dev_reset,
  input wire logic exec_idle,
  input wire logic cmd_error,
  input wire logic exec_error,
  input wire logic dev_error,
  input wire logic query_error,
  input wire logic rxd_parity_error,
  input wire logic err_valid,
  input wire logic [7:0] err_code_in,
  input wire logic excess_output_volts_flag,
  input wire logic thermal_limit_flag,
  input wire logic unregulated_flag,
  input wire logic calibration_busy,
  input wire logic trigger_wait_flag,
  input wire logic voltage_regulated_flag,
  input wire logic current_limited_flag,
  input wire logic remote_inhibit_level,
  input wire logic [ISR_SET_W-1:0] set_current,
  input wire logic [ISR_SET_W-1:0] set_voltage,
  input wire logic [ISR_SET_W-1:0] set_voltage_max,
  input wire logic [ISR_SET_W-1:0] set_voltage_step,
  output logic recall_valid,
  output logic [4*ISR_SET_W-1:0] recall_settings,
  output logic trigger_pulse,
  output logic trigger_source_bus,
  output logic remote_mode,
  output logic local_key_locked,
  output logic [7:0] request_status
);
  // ****************************************
  // Command decode
  // ****************************************
  isr_state_t state;
  logic take;
  logic is_q;
  logic slot_ok;
  logic [ISR_SLOT_AW-1:0] slot_idx;
  logic [7:0] slot_off;

  assign cmd_ready = (state == ISR_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign is_q = take && (cmd_code == ISR_ESE_Q || cmd_code == ISR_ESR_Q ||
    cmd_code == ISR_PSC_Q || cmd_code == ISR_SRE_Q || cmd_code == ISR_STB_Q ||
    cmd_code == ISR_ERR_Q || cmd_code == ISR_QEV_Q || cmd_code == ISR_QCD_Q ||
    cmd_code == ISR_QEN_Q || cmd_code == ISR_OEV_Q || cmd_code == ISR_OCD_Q ||
    cmd_code == ISR_OEN_Q);
  // [R13] slot range check
  assign slot_ok = (cmd_arg >= ISR_SLOT_FIRST) && (cmd_arg <= ISR_SLOT_LAST);
  assign slot_off = cmd_arg - ISR_SLOT_FIRST;
  assign slot_idx = slot_off[ISR_SLOT_AW-1:0];

  function automatic logic hit(input isr_cmd_t c);
    hit = take && (cmd_code == c);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] std_event_status, std_event_enable, stb, summary_enable_mask, qev, qen, oev, oen, err_code;
  logic [7:0] nv_stb, nv_ese, nv_qen, nv_oen;
  logic [QUES_W-1:0] qcond, qprev, qin;
  logic [OPER_W-1:0] ocond, oprev, oin;
  logic psc;
  logic [7:0] se_evt, sb_sum;
  logic [7:0] sb_keep;
  logic opc_set;

  assign qin = {unregulated_flag, thermal_limit_flag, excess_output_volts_flag};
  assign oin = {remote_inhibit_level, current_limited_flag, voltage_regulated_flag,
    trigger_wait_flag, calibration_busy};
  assign request_status = stb;
  // Status bits that survive this edge; a read drops stale ones from service request
  assign sb_keep = hit(ISR_STB_Q) ? REG_RST : stb;

  // [R3] event bit placement
  always_comb begin
    se_evt = REG_RST;
    se_evt[SE_OPC] = opc_set;
    se_evt[SE_QYE] = query_error;
    se_evt[SE_DDE] = dev_error;
    se_evt[SE_EXE] = exec_error || ((hit(ISR_SAV) || hit(ISR_RCL)) && !slot_ok);
    se_evt[SE_CME] = cmd_error;
    se_evt[SE_PON] = dev_reset;
  end

  // [R23] summaries from event and mask
  always_comb begin
    sb_sum = REG_RST;
    // [R19] questionable summary
    sb_sum[SB_QUES] = |(qev & qen);
    // [R4] event summary
    sb_sum[SB_ESB] = |(std_event_status & std_event_enable);
    // [R22] operation summary
    sb_sum[SB_OPER] = |(oev & oen);
    // [R9] request service from masked status
    sb_sum[SB_RQS] = |((sb_keep | sb_sum) & summary_enable_mask & SB_NO_RQS);
  end

  // [R2] [R7] [R8] standard event enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      std_event_enable <= REG_RST;
    end else if (dev_reset) begin
      std_event_enable <= psc ? REG_RST : nv_ese;
    end else if (hit(ISR_ESE_W)) begin
      std_event_enable <= cmd_arg;
    end
  end

  // [R1] [R5] [R7] standard event status, set wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      std_event_status <= ESR_RST;
    end else if (hit(ISR_CLS) || hit(ISR_ESR_Q) || (dev_reset && psc)) begin
      std_event_status <= se_evt & SE_USED;
    end else begin
      std_event_status <= (std_event_status | se_evt) & SE_USED;
    end
  end

  // [R1] [R10] [R11] status byte, restored under [R8]
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stb <= REG_RST;
    end else if (dev_reset && !psc) begin
      stb <= nv_stb;
    end else if (hit(ISR_CLS)) begin
      stb <= REG_RST;
    end else if (hit(ISR_STB_Q)) begin
      stb <= sb_sum;
    end else begin
      stb <= stb | sb_sum;
    end
  end

  // [R9] status byte enable mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      summary_enable_mask <= REG_RST;
    end else if (dev_reset && !psc) begin
      summary_enable_mask <= nv_stb & summary_enable_mask;
    end else if (hit(ISR_SRE_W)) begin
      summary_enable_mask <= cmd_arg;
    end
  end

  // [R8] power-on clear flag and retained copies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      psc <= 1'b1;
      nv_stb <= REG_RST;
      nv_ese <= REG_RST;
      nv_qen <= REG_RST;
      nv_oen <= REG_RST;
    end else begin
      if (hit(ISR_PSC_W)) begin
        psc <= cmd_arg[0];
      end
      if (!psc && !dev_reset) begin
        nv_stb <= stb;
        nv_ese <= std_event_enable;
        nv_qen <= qen;
        nv_oen <= oen;
      end
    end
  end

  // [R16] [R18] questionable condition and event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qcond <= '0;
      qprev <= '0;
      qev <= REG_RST;
    end else begin
      qprev <= qin;
      qcond <= hit(ISR_CLS) ? '0 : qin;
      // [R17] read clears, change latch wins
      if (hit(ISR_QEV_Q)) begin
        qev <= {5'h00, qin ^ qprev};
      end else begin
        qev <= qev | {5'h00, qin ^ qprev};
      end
    end
  end

  // [R19] [R7] questionable enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      qen <= REG_RST;
    end else if (dev_reset) begin
      qen <= psc ? REG_RST : nv_qen;
    end else if (hit(ISR_QEN_W)) begin
      qen <= cmd_arg;
    end
  end

  // [R20] [R21] operation condition and event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ocond <= '0;
      oprev <= '0;
      oev <= REG_RST;
    end else begin
      oprev <= oin;
      ocond <= oin;
      // [R1] clear-status zeroes the event
      if (hit(ISR_OEV_Q) || hit(ISR_CLS)) begin
        oev <= {3'h0, oin ^ oprev};
      end else begin
        oev <= oev | {3'h0, oin ^ oprev};
      end
    end
  end

  // [R22] [R7] operation enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oen <= REG_RST;
    end else if (dev_reset) begin
      oen <= psc ? REG_RST : nv_oen;
    end else if (hit(ISR_OEN_W)) begin
      oen <= cmd_arg;
    end
  end

  // [R14] [R1] pending error code, new error wins over clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      err_code <= ERR_NONE;
    end else if (rxd_parity_error) begin
      err_code <= ERR_PARITY;
    end else if (err_valid) begin
      err_code <= err_code_in;
    end else if (hit(ISR_CLS) || hit(ISR_ERR_Q)) begin
      err_code <= ERR_NONE;
    end
  end

  // ****************************************
  // Sequencer for completion and recall
  // ****************************************
  // [R6] completion waits for earlier commands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ISR_IDLE;
    end else begin
      case (state)
        ISR_IDLE: begin
          if (hit(ISR_RCL) && slot_ok) begin
            state <= ISR_RECALL;
          end else if ((hit(ISR_OPC) || hit(ISR_OPC_Q)) && !exec_idle) begin
            state <= ISR_OPC_WAIT;
          end
        end
        ISR_RECALL: state <= ISR_IDLE;
        ISR_OPC_WAIT: begin
          if (exec_idle) begin
            state <= ISR_IDLE;
          end
        end
        default: state <= ISR_IDLE;
      endcase
    end
  end

  logic opc_query;
  assign opc_set = (hit(ISR_OPC) && exec_idle) ||
    (state == ISR_OPC_WAIT && exec_idle && !opc_query);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opc_query <= 1'b0;
    end else if (hit(ISR_OPC_Q)) begin
      opc_query <= 1'b1;
    end else if (hit(ISR_OPC)) begin
      opc_query <= 1'b0;
    end
  end

  // ****************************************
  // Query answers
  // ****************************************
  logic [7:0] next_rsp;
  always_comb begin
    case (cmd_code)
      ISR_ESE_Q: next_rsp = std_event_enable;
      ISR_ESR_Q: next_rsp = std_event_status;
      ISR_PSC_Q: next_rsp = {7'h00, psc};
      ISR_SRE_Q: next_rsp = summary_enable_mask;
      ISR_STB_Q: next_rsp = stb;
      ISR_ERR_Q: next_rsp = err_code;
      ISR_QEV_Q: next_rsp = qev;
      ISR_QCD_Q: next_rsp = {5'h00, qcond};
      ISR_QEN_Q: next_rsp = qen;
      ISR_OEV_Q: next_rsp = oev;
      ISR_OCD_Q: next_rsp = {3'h0, ocond};
      ISR_OEN_Q: next_rsp = oen;
      default: next_rsp = REG_RST;
    endcase
  end

  logic opc_done_q;
  assign opc_done_q = opc_query && ((state == ISR_OPC_WAIT && exec_idle) ||
    (hit(ISR_OPC_Q) && exec_idle));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= REG_RST;
    end else begin
      rsp_valid <= is_q || opc_done_q || (hit(ISR_OPC_Q) && exec_idle);
      if (hit(ISR_OPC_Q) || opc_done_q) begin
        rsp_data <= OPC_TRUE;
      end else if (is_q) begin
        rsp_data <= next_rsp;
      end
    end
  end

  // ****************************************
  // Trigger, modes, save and recall
  // ****************************************
  // [R12] bus trigger gating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trigger_source_bus <= 1'b1;
      trigger_pulse <= 1'b0;
    end else begin
      trigger_pulse <= (hit(ISR_TRG) || hit(ISR_TRIG)) && trigger_source_bus;
      if (hit(ISR_RST)) begin
        trigger_source_bus <= 1'b1;
      end else if (hit(ISR_TSRC_W)) begin
        trigger_source_bus <= cmd_arg[0];
      end
    end
  end

  // [R15] remote and local modes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remote_mode <= 1'b0;
      local_key_locked <= 1'b0;
    end else if (hit(ISR_REM) || hit(ISR_RWL)) begin
      remote_mode <= 1'b1;
      local_key_locked <= hit(ISR_RWL);
    end else if (hit(ISR_LOC)) begin
      remote_mode <= 1'b0;
      local_key_locked <= 1'b0;
    end
  end

  // [R13] slot store
  isr_slot_mem u_slots (
    .core_clk(core_clk),
    .wr_en(hit(ISR_SAV) && slot_ok),
    .wr_addr(slot_idx),
    .wr_data({set_voltage_step, set_voltage_max, set_voltage, set_current}),
    .rd_en(hit(ISR_RCL) && slot_ok),
    .rd_addr(slot_idx),
    .rd_data(recall_settings)
  );
  assign recall_valid = (state == ISR_RECALL);

  // ****************************************
  // Checks
  // ****************************************
  clear_status_a: assert property (@(posedge core_clk) disable iff (rst) // [R1]
    hit(ISR_CLS) && !err_valid && !rxd_parity_error |=> err_code == ERR_NONE && qcond == '0)
    else $error("clear status left state");
  esr_read_a: assert property (@(posedge core_clk) disable iff (rst) // [R5]
    hit(ISR_ESR_Q) |=> rsp_valid && rsp_data == $past(std_event_status) && std_event_status == ($past(se_evt) & SE_USED))
    else $error("event read did not clear");
  esb_summary_a: assert property (@(posedge core_clk) disable iff (rst) // [R4]
    |(std_event_status & std_event_enable) && !dev_reset && !hit(ISR_CLS) |=> stb[SB_ESB])
    else $error("event summary missing");
  rqs_summary_a: assert property (@(posedge core_clk) disable iff (rst) // [R9]
    |(stb & summary_enable_mask & SB_NO_RQS) && !dev_reset && !hit(ISR_CLS) && !hit(ISR_STB_Q)
    |=> stb[SB_RQS])
    else $error("request service missing");
  ques_latch_a: assert property (@(posedge core_clk) disable iff (rst) // [R18]
    qin[0] != qprev[0] |=> qev[0])
    else $error("questionable change not latched");
  oper_latch_a: assert property (@(posedge core_clk) disable iff (rst) // [R21]
    oin[2] != oprev[2] |=> oev[2])
    else $error("operation change not latched");
  trig_gate_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
    trigger_pulse |-> $past(trigger_source_bus))
    else $error("trigger without bus source");
  opc_wait_a: assert property (@(posedge core_clk) disable iff (rst) // [R6]
    hit(ISR_OPC) && !exec_idle |=> !std_event_status[SE_OPC] || $past(std_event_status[SE_OPC]))
    else $error("completion set too early");
  psc_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [R7]
    dev_reset && psc |=> qen == REG_RST && oen == REG_RST && std_event_enable == REG_RST)
    else $error("power-on clear missed");
  recall_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
    hit(ISR_RCL) && slot_ok |=> recall_valid ##1 !recall_valid)
    else $error("recall timing wrong");
endmodule
`default_nettype wire

//--- isr_host_model.sv
// Host side model that offers commands over the ready/valid handshake
`timescale 1ns/100ps
`default_nettype none
module isr_host_model
  import isr_pkg::*;
(
  input wire logic core_clk,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output isr_cmd_t cmd_code,
  output logic [7:0] cmd_arg
);
  // Idle cycles before each offer, so the host can be prompt or slow
  int gap = 0;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = ISR_CLS;
    cmd_arg = 8'h00;
  end
  // ****************************************
  // Command offer
  // ****************************************
  task automatic send(input isr_cmd_t code, input logic [7:0] arg);
    int waited;
    waited = 0;
    repeat (gap) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_arg = arg;
    do begin
      @(posedge core_clk);
      waited++;
    end while (cmd_ready !== 1'b1 && waited < 200);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = isr_cmd_t'(~code);
    cmd_arg = ~arg;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench of the status reporting block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import isr_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid;
  logic cmd_ready;
  isr_cmd_t cmd_code;
  logic [7:0] cmd_arg;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic exec_idle = 1'b1;
  logic [6:0] ev = 7'h00;
  logic [7:0] err_code_in = 8'h00;
  logic [2:0] ques_in = 3'h0;
  logic [4:0] oper_in = 5'h00;
  logic [63:0] settings = 64'h0;
  logic recall_valid;
  logic [63:0] recall_settings;
  logic trigger_pulse;
  logic trigger_source_bus;
  logic remote_mode;
  logic local_key_locked;
  logic [7:0] request_status;
  logic [7:0] exp_q[$];
  logic [31:0] lfsr = 32'h0001619e;
  logic [63:0] s1;
  logic [63:0] s50;
  logic [7:0] r;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  isr_status_core isr_status_core_i (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .dev_reset(ev[5]), .exec_idle(exec_idle), .cmd_error(ev[0]), .exec_error(ev[1]),
    .dev_error(ev[2]), .query_error(ev[3]), .rxd_parity_error(ev[4]), .err_valid(ev[6]),
    .err_code_in(err_code_in), .excess_output_volts_flag(ques_in[0]),
    .thermal_limit_flag(ques_in[1]), .unregulated_flag(ques_in[2]),
    .calibration_busy(oper_in[0]), .trigger_wait_flag(oper_in[1]),
    .voltage_regulated_flag(oper_in[2]), .current_limited_flag(oper_in[3]),
    .remote_inhibit_level(oper_in[4]), .set_current(settings[15:0]),
    .set_voltage(settings[31:16]), .set_voltage_max(settings[47:32]),
    .set_voltage_step(settings[63:48]), .recall_valid(recall_valid),
    .recall_settings(recall_settings), .trigger_pulse(trigger_pulse),
    .trigger_source_bus(trigger_source_bus), .remote_mode(remote_mode),
    .local_key_locked(local_key_locked), .request_status(request_status));

  isr_host_model isr_host_model_i (.core_clk(core_clk), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmd(input isr_cmd_t code, input logic [7:0] arg);
    isr_host_model_i.send(code, arg);
  endtask
  task automatic query(input isr_cmd_t code, input logic [7:0] exp);
    exp_q.push_back(exp);
    isr_host_model_i.send(code, 8'h00);
  endtask
  task automatic pulse(input logic [6:0] which);
    @(negedge core_clk);
    ev = which;
    @(negedge core_clk);
    ev = 7'h00;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Answer monitor and timeout
  // ****************************************
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) begin
      check("rsp_data", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rsp_data);
    end
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      $display("mismatch run_length expected finished seen hung");
      print_verdict();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    query(ISR_ESR_Q, ESR_RST);
    query(ISR_ESR_Q, REG_RST);
    query(ISR_PSC_Q, 8'h01);
    query(ISR_ERR_Q, ERR_NONE);
    pulse(7'h0f);
    query(ISR_ESR_Q, 8'h3c);
    $display("test reset_events done");
    r = 8'(next_rand());
    cmd(ISR_ESE_W, r);
    query(ISR_ESE_Q, r);
    cmd(ISR_SRE_W, r & SB_NO_RQS);
    query(ISR_SRE_Q, r & SB_NO_RQS);
    cmd(ISR_ESE_W, 8'h20);
    cmd(ISR_SRE_W, 8'h20);
    pulse(7'h01);
    idle(3);
    check("request_status", 8'h60, request_status);
    query(ISR_STB_Q, 8'h60);
    query(ISR_ESR_Q, 8'h20);
    query(ISR_STB_Q, 8'h60);
    query(ISR_STB_Q, 8'h00);
    cmd(ISR_ESE_W, 8'h00);
    cmd(ISR_SRE_W, 8'h00);
    $display("test summary done");
    ques_in = 3'h1;
    idle(2);
    query(ISR_QCD_Q, 8'h01);
    query(ISR_QEV_Q, 8'h01);
    query(ISR_QEV_Q, 8'h00);
    cmd(ISR_QEN_W, 8'h04);
    ques_in = 3'h5;
    idle(3);
    check("ques_summary", 8'h08, request_status & 8'h08);
    ques_in = 3'h0;
    idle(2);
    query(ISR_QEV_Q, 8'h05);
    query(ISR_STB_Q, 8'h08);
    cmd(ISR_QEN_W, 8'h00);
    r = {3'h0, 5'(next_rand()) | 5'h01};
    oper_in = r[4:0];
    idle(2);
    query(ISR_OCD_Q, r);
    query(ISR_OEV_Q, r);
    query(ISR_OEV_Q, 8'h00);
    cmd(ISR_OEN_W, 8'h1f);
    oper_in = 5'h00;
    idle(3);
    check("oper_summary", 8'h80, request_status & 8'h80);
    query(ISR_OEV_Q, r);
    query(ISR_STB_Q, 8'h80);
    cmd(ISR_OEN_W, 8'h00);
    $display("test conditions done");
    err_code_in = 8'(next_rand());
    pulse(7'h40);
    query(ISR_ERR_Q, err_code_in);
    query(ISR_ERR_Q, ERR_NONE);
    pulse(7'h50);
    query(ISR_ERR_Q, ERR_PARITY);
    pulse(7'h13);
    oper_in = 5'h02;
    idle(2);
    oper_in = 5'h00;
    cmd(ISR_ESE_W, 8'h30);
    cmd(ISR_CLS, 8'h00);
    query(ISR_ESR_Q, 8'h00);
    query(ISR_OEV_Q, 8'h00);
    query(ISR_STB_Q, 8'h00);
    query(ISR_ERR_Q, ERR_NONE);
    cmd(ISR_ESE_W, 8'h00);
    exec_idle = 1'b0;
    cmd(ISR_OPC, 8'h00);
    idle(4);
    check("cmd_ready", 1'b0, cmd_ready);
    exec_idle = 1'b1;
    idle(2);
    query(ISR_ESR_Q, OPC_TRUE);
    query(ISR_OPC_Q, OPC_TRUE);
    $display("test clear_complete done");
    isr_host_model_i.gap = 2;
    cmd(ISR_TRG, 8'h00);
    check("trigger_pulse", 1'b1, trigger_pulse);
    cmd(ISR_TRIG, 8'h00);
    check("trigger_pulse", 1'b1, trigger_pulse);
    cmd(ISR_TSRC_W, 8'h00);
    check("trigger_source_bus", 1'b0, trigger_source_bus);
    cmd(ISR_TRG, 8'h00);
    check("trigger_pulse", 1'b0, trigger_pulse);
    cmd(ISR_TSRC_W, 8'h01);
    s1 = {next_rand(), next_rand()};
    settings = s1;
    cmd(ISR_SAV, ISR_SLOT_FIRST);
    s50 = {next_rand(), next_rand()};
    settings = s50;
    cmd(ISR_SAV, ISR_SLOT_LAST);
    settings = {next_rand(), next_rand()};
    isr_host_model_i.gap = 0;
    cmd(ISR_RCL, ISR_SLOT_LAST);
    check("recall_valid", 1'b1, recall_valid);
    check("recall_settings", s50, recall_settings);
    cmd(ISR_RCL, ISR_SLOT_FIRST);
    check("recall_settings", s1, recall_settings);
    cmd(ISR_SAV, 8'h33);
    query(ISR_ESR_Q, 8'h10);
    cmd(ISR_RCL, 8'h00);
    query(ISR_ESR_Q, 8'h10);
    cmd(ISR_REM, 8'h00);
    check("remote_mode", 1'b1, remote_mode);
    cmd(ISR_LOC, 8'h00);
    check("remote_mode", 1'b0, remote_mode);
    cmd(ISR_RWL, 8'h00);
    check("remote_mode", 1'b1, remote_mode);
    check("local_key_locked", 1'b1, local_key_locked);
    $display("test trigger_slots_modes done");
    cmd(ISR_ESE_W, 8'hff);
    cmd(ISR_QEN_W, 8'h07);
    cmd(ISR_OEN_W, 8'h1f);
    pulse(7'h20);
    query(ISR_ESE_Q, 8'h00);
    query(ISR_QEN_Q, 8'h00);
    query(ISR_OEN_Q, 8'h00);
    query(ISR_ESR_Q, ESR_RST);
    cmd(ISR_PSC_W, 8'h00);
    query(ISR_PSC_Q, 8'h00);
    r = 8'(next_rand());
    cmd(ISR_ESE_W, r);
    cmd(ISR_QEN_W, ~r);
    cmd(ISR_OEN_W, r ^ 8'h5a);
    pulse(7'h20);
    query(ISR_ESE_Q, r);
    query(ISR_QEN_Q, ~r);
    query(ISR_OEN_Q, r ^ 8'h5a);
    $display("test power_on_clear done");
    idle(3);
    check("answers_pending", 64'h0, 64'(exp_q.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
